// ---- reset_and_fault_exception_seq.sv ----
// Reset entry, unsupported-instruction and fault-on-fault sequencer.
// Assumes memory answers one longword read at a time with done and fault.
// Functional notes
// - Reset input always wins over other exceptions.
// - Reset abandons current work without resume.
// - Reset sets supervisor, clears trace flag.
// - Reset clears master flag, mask to seven.
// - Reset zeroes the vector base pointer.
// - Reset invalidates and disables local memories.
// - Wait 80 cycles after release, sample breakpoint.
// - Read SP at 0, PC at 4.
// - Execute from PC after first fetch.
// - Fault before first instruction halts core.
// - Missing optional unit raises vector 0x61.
// - Fault during exception processing halts immediately.
// - Only reset leaves the halted state.
module reset_and_fault_exception_seq
	import exc_seq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reset_in_pin_n,
	input wire logic debugBreakReq,
	input bus_rsp_type busRsp,
	input wire logic firstFetchDone,
	input wire logic instrFault,
	input wire logic optUnitMissing,
	input wire logic excDone,
	output bus_req_type busReq_q,
	output logic [15:0] status_word_q,
	output logic [31:0] vector_base_pointer_q,
	output logic [31:0] stackPointer_q,
	output logic [31:0] programCounter_q,
	output logic localMemValid_q,
	output logic breakSampled_q,
	output logic running_q,
	output logic halted_q,
	output logic excTaken_q,
	output logic [7:0] excVector_q
);
	// ****************************************
	// Reset source
	// ****************************************
	logic resetActive;

	// reset outranks all
	// The pin and the block reset both act as the reset exception source.
	assign resetActive = !rst_n || !reset_in_pin_n;

	// ****************************************
	// Event decode
	// ****************************************
	state_type state_q, state_d;
	logic [6:0] waitCnt_q, waitCnt_d;
	logic waitOver, startFetch, fetching, fetchFault, spTaken, pcTaken;
	logic earlyFault, started, runFault, runTrap, doubleFault, excReturn;

	assign waitOver = (state_q == ST_WAIT) && (waitCnt_q == RESET_WAIT_LAST);
	// A breakpoint seen in the wait keeps the core from fetching until reset.
	assign startFetch = waitOver && !breakSampled_q && !debugBreakReq;
	assign fetching = (state_q == ST_FETCH_SP) || (state_q == ST_FETCH_PC);
	assign fetchFault = fetching && busRsp.fault;
	assign spTaken = (state_q == ST_FETCH_SP) && !busRsp.fault && busRsp.done;
	assign pcTaken = (state_q == ST_FETCH_PC) && !busRsp.fault && busRsp.done;
	assign earlyFault = (state_q == ST_FIRST) && instrFault;
	assign started = (state_q == ST_FIRST) && !instrFault && firstFetchDone;
	// A real fault outranks the unit-missing trap.
	assign runFault = (state_q == ST_RUN) && instrFault;
	assign runTrap = (state_q == ST_RUN) && !instrFault && optUnitMissing;
	assign doubleFault = (state_q == ST_EXC) && instrFault;
	assign excReturn = (state_q == ST_EXC) && !instrFault && excDone;

	// ****************************************
	// Sequencer state
	// ****************************************
	bus_req_type busReq_d;

	always_comb
	begin
		state_d = state_q;
		waitCnt_d = waitCnt_q;
		busReq_d = busReq_q;
		if (resetActive)
		begin
			state_d = ST_WAIT;
			waitCnt_d = '0;
			busReq_d = '0;
		end
		else
		begin
			unique case (state_q)
				ST_WAIT:
				begin
					if (!waitOver)
						waitCnt_d = waitCnt_q + 7'h01;
					else if (startFetch)
					begin
						state_d = ST_FETCH_SP;
						busReq_d.req = 1'b1;
						busReq_d.addr = SP_FETCH_ADDR;
					end
				end
				ST_FETCH_SP:
				begin
					if (fetchFault)
					begin
						busReq_d = '0;
						state_d = ST_HALT;
					end
					else if (spTaken)
					begin
						busReq_d.addr = PC_FETCH_ADDR;
						state_d = ST_FETCH_PC;
					end
				end
				ST_FETCH_PC:
				begin
					if (fetchFault)
					begin
						busReq_d = '0;
						state_d = ST_HALT;
					end
					else if (pcTaken)
					begin
						busReq_d = '0;
						state_d = ST_FIRST;
					end
				end
				ST_FIRST:
				begin
					if (earlyFault)
						state_d = ST_HALT;
					else if (started)
						state_d = ST_RUN;
				end
				ST_RUN:
				begin
					if (runFault || runTrap)
						state_d = ST_EXC;
				end
				ST_EXC:
				begin
					if (doubleFault)
						state_d = ST_HALT;
					else if (excReturn)
						state_d = ST_RUN;
				end
				ST_HALT:
				begin
					state_d = ST_HALT;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		state_q <= state_d;
		waitCnt_q <= waitCnt_d;
		busReq_q <= busReq_d;
	end

	// ****************************************
	// Status word, vector base and local memories
	// ****************************************
	logic [15:0] status_d;
	logic [31:0] vbr_d;
	logic memValid_d;

	always_comb
	begin
		status_d = status_word_q;
		vbr_d = vector_base_pointer_q;
		memValid_d = localMemValid_q;
		if (resetActive)
		begin
			status_d = STATUS_RESET;
			status_d[SUPERVISOR_BIT] = 1'b1;
			status_d[TRACE_BIT] = 1'b0;
			status_d[MASTER_BIT] = 1'b0;
			status_d[IPL_LSB +: 3] = IPL_RESET;
			vbr_d = VBR_RESET;
			memValid_d = 1'b0;
		end
		else if (runFault || runTrap)
		begin
			// Exception entry runs in supervisor state with tracing off.
			status_d[SUPERVISOR_BIT] = 1'b1;
			status_d[TRACE_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		status_word_q <= status_d;
		vector_base_pointer_q <= vbr_d;
		localMemValid_q <= memValid_d;
	end

	// ****************************************
	// Start values
	// ****************************************
	logic [31:0] sp_d, pc_d;

	always_comb
	begin
		sp_d = stackPointer_q;
		pc_d = programCounter_q;
		if (!rst_n)
		begin
			// The pin alone keeps the last start values until the new reads.
			sp_d = '0;
			pc_d = '0;
		end
		else if (!resetActive)
		begin
			if (spTaken)
				sp_d = busRsp.data;
			if (pcTaken)
				pc_d = busRsp.data;
		end
	end

	always_ff @(posedge clk)
	begin
		stackPointer_q <= sp_d;
		programCounter_q <= pc_d;
	end

	// ****************************************
	// Run, halt and exception flags
	// ****************************************
	logic brk_d, running_d, halted_d, excTaken_d;
	logic [7:0] excVector_d;

	always_comb
	begin
		brk_d = breakSampled_q;
		running_d = running_q;
		halted_d = halted_q;
		excTaken_d = 1'b0;
		excVector_d = excVector_q;
		if (resetActive)
		begin
			brk_d = 1'b0;
			running_d = 1'b0;
			halted_d = 1'b0;
			excVector_d = NO_VECTOR;
		end
		else
		begin
			if ((state_q == ST_WAIT) && debugBreakReq)
				brk_d = 1'b1;
			if (started)
				running_d = 1'b1;
			if (fetchFault || earlyFault || doubleFault)
			begin
				running_d = 1'b0;
				halted_d = 1'b1;
			end
			if (state_q == ST_HALT)
			begin
				running_d = 1'b0;
				halted_d = 1'b1;
			end
			// A fault taken while running carries no vector of its own here.
			if (runFault)
			begin
				excTaken_d = 1'b1;
				excVector_d = NO_VECTOR;
			end
			if (runTrap)
			begin
				excTaken_d = 1'b1;
				excVector_d = UNSUPPORTED_VECTOR;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		breakSampled_q <= brk_d;
		running_q <= running_d;
		halted_q <= halted_d;
		excTaken_q <= excTaken_d;
		excVector_q <= excVector_d;
	end
endmodule // reset_and_fault_exception_seq

// ---- exc_seq_pkg.sv ----
// Package for the reset and fault exception sequencer.
// Assumes a single 40 MHz core clock and a synchronous active-low reset.
package exc_seq_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned RESET_WAIT_CYCLES = 80;
	localparam logic [6:0] RESET_WAIT_LAST = 7'(RESET_WAIT_CYCLES - 1);

	// ****************************************
	// Status word layout and reset values
	// ****************************************
	localparam int unsigned TRACE_BIT = 15;
	localparam int unsigned SUPERVISOR_BIT = 13;
	localparam int unsigned MASTER_BIT = 12;
	localparam int unsigned IPL_LSB = 8;
	localparam logic [2:0] IPL_RESET = 3'h7;
	localparam logic [15:0] STATUS_RESET = 16'h2700;

	// ****************************************
	// Addresses and vectors
	// ****************************************
	localparam logic [31:0] VBR_RESET = 32'h0000_0000;
	localparam logic [31:0] SP_FETCH_ADDR = 32'h0000_0000;
	localparam logic [31:0] PC_FETCH_ADDR = 32'h0000_0004;
	localparam logic [7:0] UNSUPPORTED_VECTOR = 8'h61;
	localparam logic [7:0] NO_VECTOR = 8'h00;

	typedef enum {
		ST_WAIT,
		ST_FETCH_SP,
		ST_FETCH_PC,
		ST_FIRST,
		ST_RUN,
		ST_EXC,
		ST_HALT
	} state_type;

	typedef struct packed {
		logic req;
		logic [31:0] addr;
	} bus_req_type;

	typedef struct packed {
		logic done;
		logic fault;
		logic [31:0] data;
	} bus_rsp_type;
endpackage : exc_seq_pkg

// ---- exc_seq_sva.sv ----
// Port checker for the exception sequencer.
// Assumes it is bound onto the sequencer.
module exc_seq_sva
	import exc_seq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reset_in_pin_n,
	input bus_rsp_type busRsp,
	input bus_req_type busReq_q,
	input logic [15:0] status_word_q,
	input logic [31:0] vector_base_pointer_q,
	input logic [31:0] programCounter_q,
	input logic localMemValid_q,
	input logic breakSampled_q,
	input logic running_q,
	input logic halted_q
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence rstSeen;
		!reset_in_pin_n;
	endsequence
	sequence readDone(logic [31:0] a);
		busReq_q.req && busRsp.done && busReq_q.addr == a && reset_in_pin_n;
	endsequence
	chk_rst_status: assert property (rstSeen |=> status_word_q == STATUS_RESET)
		else $error("status word not reset");
	chk_rst_base: assert property (rstSeen |=> !vector_base_pointer_q && !localMemValid_q)
		else $error("base or memories not reset");
	chk_rst_abort: assert property (rstSeen |=> !halted_q && !running_q && !busReq_q.req)
		else $error("work not abandoned");
	chk_wait_len: assert property ($rose(reset_in_pin_n) |-> ##79 !busReq_q.req ##1
		(busReq_q.req || breakSampled_q)) else $error("wait length wrong");
	chk_addr_order: assert property (readDone(SP_FETCH_ADDR) |=> busReq_q.req
		&& busReq_q.addr == PC_FETCH_ADDR) else $error("second read wrong");
	chk_pc_load: assert property (readDone(PC_FETCH_ADDR) |=> !busReq_q.req
		&& programCounter_q == $past(busRsp.data)) else $error("start address wrong");
	chk_fetch_fault: assert property (busReq_q.req && busRsp.fault && reset_in_pin_n
		|=> halted_q && !busReq_q.req) else $error("no halt on fault");
	chk_halt_sticky: assert property (halted_q && reset_in_pin_n |=> halted_q)
		else $error("halt left without reset");
endmodule // exc_seq_sva

bind reset_and_fault_exception_seq exc_seq_sva u_exc_seq_sva (
	.clk(clk),
	.rst_n(rst_n),
	.reset_in_pin_n(reset_in_pin_n),
	.busRsp(busRsp),
	.busReq_q(busReq_q),
	.status_word_q(status_word_q),
	.vector_base_pointer_q(vector_base_pointer_q),
	.programCounter_q(programCounter_q),
	.localMemValid_q(localMemValid_q),
	.breakSampled_q(breakSampled_q),
	.running_q(running_q),
	.halted_q(halted_q)
);

// ---- exc_mem_model.sv ----
// System memory answering longword reads.
// Assumes one read at a time, held until answered.
module exc_mem_model
	import exc_seq_pkg::*;
(
	input wire logic clk,
	input bus_req_type busReq,
	input wire logic [3:0] lat,
	input wire logic faultOn,
	output bus_rsp_type busRsp
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt = 0;
	initial busRsp = '0;
	always @(posedge clk)
	begin
		busRsp.done <= 0;
		busRsp.fault <= 0;
		busRsp.data <= ~busRsp.data;
		if (!busReq.req)
			cnt <= 0;
		else if (cnt < lat)
			cnt <= cnt + 1;
		else if (!busRsp.done && !busRsp.fault)
		begin
			busRsp.done <= !faultOn;
			busRsp.fault <= faultOn;
			busRsp.data <= busReq.addr ^ 32'h1234_5670;
			cnt <= 0;
		end
	end
endmodule // exc_mem_model

// ---- reset_and_fault_exception_seq_tb.sv ----
// Bench for the exception sequencer.
// Assumes the memory model on the far side.
module reset_and_fault_exception_seq_tb
	import exc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, reset_in_pin_n = 0, debugBreakReq = 0, firstFetchDone = 0;
	logic instrFault = 0, optUnitMissing = 0, excDone = 0, faultOn = 0;
	logic [3:0] lat = 0;
	bus_req_type busReq_q;
	bus_rsp_type busRsp;
	logic [15:0] status_word_q;
	logic [31:0] vector_base_pointer_q, stackPointer_q, programCounter_q;
	logic localMemValid_q, breakSampled_q, running_q, halted_q, excTaken_q;
	logic [7:0] excVector_q;
	int fails = 0, checksDone = 0, cyc = 0, n;
	reset_and_fault_exception_seq u_reset_and_fault_exception_seq (
		.clk(clk),
		.rst_n(rst_n),
		.reset_in_pin_n(reset_in_pin_n),
		.debugBreakReq(debugBreakReq),
		.busRsp(busRsp),
		.firstFetchDone(firstFetchDone),
		.instrFault(instrFault),
		.optUnitMissing(optUnitMissing),
		.excDone(excDone),
		.busReq_q(busReq_q),
		.status_word_q(status_word_q),
		.vector_base_pointer_q(vector_base_pointer_q),
		.stackPointer_q(stackPointer_q),
		.programCounter_q(programCounter_q),
		.localMemValid_q(localMemValid_q),
		.breakSampled_q(breakSampled_q),
		.running_q(running_q),
		.halted_q(halted_q),
		.excTaken_q(excTaken_q),
		.excVector_q(excVector_q)
	);
	exc_mem_model u_exc_mem_model (
		.clk(clk),
		.busReq(busReq_q),
		.lat(lat),
		.faultOn(faultOn),
		.busRsp(busRsp)
	);
	initial forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d fails=%0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Bit 0 first fetch, bit 1 fault, bit 2 missing unit, bit 3 exception done.
	task automatic pulse(input logic [3:0] sel);
		{excDone, optUnitMissing, instrFault, firstFetchDone} <= sel;
		@(posedge clk);
		{excDone, optUnitMissing, instrFault, firstFetchDone} <= 4'h0;
		@(posedge clk);
	endtask
	task automatic boot(input logic full);
		rst_n <= !full;
		reset_in_pin_n <= 0;
		repeat (6) @(posedge clk);
		rst_n <= 1;
		reset_in_pin_n <= 1;
		@(posedge clk);
		cmp(status_word_q, STATUS_RESET);
		cmp(vector_base_pointer_q, VBR_RESET);
		cmp({localMemValid_q, halted_q, running_q}, 0);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!busReq_q.req && n < 200);
	endtask
	task automatic tBoot();
		boot(1);
		cmp(n, RESET_WAIT_CYCLES);
		cmp(busReq_q.addr, SP_FETCH_ADDR);
		for (n = 0; busReq_q.req && n < 20; n++) @(posedge clk);
		cmp(stackPointer_q, 32'h1234_5670);
		cmp(programCounter_q, 32'h1234_5674);
		pulse(4'h1);
		cmp(running_q, 1);
		$display("boot test done");
	endtask
	task automatic tExc();
		pulse(4'h4);
		cmp({excTaken_q, excVector_q}, {1'b1, UNSUPPORTED_VECTOR});
		cmp({status_word_q[SUPERVISOR_BIT], status_word_q[TRACE_BIT]}, 2'h2);
		pulse(4'h8);
		pulse(4'h2);
		cmp({excTaken_q, excVector_q}, {1'b1, NO_VECTOR});
		pulse(4'h2);
		cmp(halted_q, 1);
		pulse(4'h4);
		cmp(halted_q, 1);
		$display("exception test done");
	endtask
	task automatic tFault();
		faultOn <= 1;
		lat <= 3;
		boot(0);
		for (n = 0; !halted_q && n < 20; n++) @(posedge clk);
		cmp({halted_q, busReq_q.req}, 2'h2);
		faultOn <= 0;
		debugBreakReq <= 1;
		boot(0);
		cmp({busReq_q.req, breakSampled_q}, 2'h1);
		debugBreakReq <= 0;
		$display("fault and break test done");
	endtask
	always @(posedge clk)
		if (++cyc == 3000)
		begin
			fails++;
			give_verdict();
		end
	initial
	begin
		tBoot();
		tExc();
		tFault();
		give_verdict();
	end
endmodule // reset_and_fault_exception_seq_tb
